// ### rtl/plc_regs.vh
// Constants for the LED, reset and power-down control block.
// Assumes a 100 MHz core clock and the plain register port described in plc_top.v.
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PLC_OFS_CTRL_A 4'h0
`define PLC_OFS_CTRL_B 4'h4
`define PLC_OFS_STAT 4'h8
`define PLC_OFS_IRQ_STAT 4'hC
// Index 0x10 would not fit 4 bits, so mask sits on the 5-bit address
`define PLC_OFS_IRQ_MASK 5'h10
`define PLC_ADDR_W 5

// ----------------------------------------
// Control register fields (one per port)
// ----------------------------------------
`define PLC_CTRL_MODE3 0
`define PLC_CTRL_DUPLEX 1
`define PLC_CTRL_IRQ_EN 2
`define PLC_CTRL_RST 3'h0

// ----------------------------------------
// LED modes
// ----------------------------------------
`define PLC_MODE1 2'h1
`define PLC_MODE2 2'h2
`define PLC_MODE3 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLC_CLK_MHZ 100
`define PLC_RST_MIN_NS 1000
`define PLC_RST_CYC ((`PLC_RST_MIN_NS * `PLC_CLK_MHZ + 999) / 1000)
`define PLC_BLINK_MS 50
`define PLC_BLINK_CYC (`PLC_BLINK_MS * 1000 * `PLC_CLK_MHZ)

`endif

// ### rtl/plc_top.v
// LED indicator, hardware reset and power-down/interrupt pin logic for two PHY ports.
// Assumes port status (link, speed, activity, collision, duplex, irq) comes from
// logic on sys_clk; pins and reset pin are asynchronous and are synchronised here.
//
// Overview of operation
// - Three indicators per port, strap or register mode
// - Indicator polarity follows strap level at reset
// - Mode 1: link indicator shows link only
// - Modes 2,3: link on, blinks with activity
// - Speed indicator on at 100, off at 10
// - Mode 1: third indicator shows activity
// - Mode 2: third indicator shows collision
// - Mode 3: register selects collision or duplex
// - Reset pin low 1 us starts reset
// - Hardware reset restores register defaults
// - Hardware reset re-samples all straps
// - Default pin function is active-low power-down
// - Interrupt mode: open-drain, pulled low on irq
// - Interrupt mode only after register configuration
`timescale 1ns/1ns
`include "plc_regs.vh"

module plc_top #(
    parameter BLINK_CYC = `PLC_BLINK_CYC,
    parameter RST_CYC = `PLC_RST_CYC
) (
    input wire sys_clk,
    input wire rstn,
    input wire clk_en,
    // Hardware reset pin, active low, asynchronous
    input wire hw_reset_n_pin,
    // Register port
    input wire [4:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output wire irq,
    // Port status from the PHY core (sys_clk domain)
    input wire [1:0] link_good,
    input wire [1:0] speed_100,
    input wire [1:0] activity,
    input wire [1:0] collision,
    input wire [1:0] full_duplex,
    input wire [1:0] port_irq,
    // LED-mode strap select (1 = mode 1, 0 = mode 2), sampled at reset
    input wire mode_strap_pin,
    // Indicator pins, two-way: strap input while not driven
    input wire link_indicator_port_a_in,
    output reg link_indicator_port_a_out,
    output reg link_indicator_port_a_oe,
    input wire link_indicator_port_b_in,
    output reg link_indicator_port_b_out,
    output reg link_indicator_port_b_oe,
    input wire speed_indicator_port_a_in,
    output reg speed_indicator_port_a_out,
    output reg speed_indicator_port_a_oe,
    input wire speed_indicator_port_b_in,
    output reg speed_indicator_port_b_out,
    output reg speed_indicator_port_b_oe,
    input wire activity_collision_indicator_port_a_in,
    output reg activity_collision_indicator_port_a_out,
    output reg activity_collision_indicator_port_a_oe,
    input wire activity_collision_indicator_port_b_in,
    output reg activity_collision_indicator_port_b_out,
    output reg activity_collision_indicator_port_b_oe,
    // Power-down input / open-drain interrupt pins
    input wire powerdown_or_irq_port_a_in,
    output wire powerdown_or_irq_port_a_out,
    output reg powerdown_or_irq_port_a_oe,
    input wire powerdown_or_irq_port_b_in,
    output wire powerdown_or_irq_port_b_out,
    output reg powerdown_or_irq_port_b_oe,
    // Power-down request per port, active high
    output reg [1:0] power_down,
    // Internal reset to the rest of the PHY, active high
    output reg phy_reset
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit order: 0 rst,1 mode,2..7 led pins,8..9 pwrdn pins
    wire [9:0] pin_raw;
    reg [9:0] sync1_reg;
    reg [9:0] sync2_reg;

    assign pin_raw = {powerdown_or_irq_port_b_in, powerdown_or_irq_port_a_in,
                      activity_collision_indicator_port_b_in, activity_collision_indicator_port_a_in,
                      speed_indicator_port_b_in, speed_indicator_port_a_in,
                      link_indicator_port_b_in, link_indicator_port_a_in,
                      mode_strap_pin, hw_reset_n_pin};

    // Two flops; only the second stage feeds logic
    // No reset here: the chain must fill with the real pin levels during reset,
    // otherwise the straps would be captured from a forced value instead of the pins
    always @(posedge sys_clk)
    begin
        if (clk_en)
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // ----------------------------------------
    // Reset pin filter
    // ----------------------------------------
    reg [7:0] rst_cnt_reg;
    reg hw_rst_reg;
    wire rst_long;

    // Short glitches under the minimum width are ignored
    assign rst_long = (rst_cnt_reg >= RST_CYC[7:0]);

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            rst_cnt_reg <= 8'h00;
            hw_rst_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            if (sync2_reg[0])
            begin
                // Pin released: reset ends, counter clears
                rst_cnt_reg <= 8'h00;
                hw_rst_reg <= 1'b0;
            end
            else
            begin
                if (!rst_long)
                    rst_cnt_reg <= rst_cnt_reg + 8'h01;
                if (rst_long)
                    hw_rst_reg <= 1'b1;
            end
        end
    end

    // Combined reset: system reset or a qualified pin reset
    wire any_rst;
    assign any_rst = !rstn || hw_rst_reg;

    always @(posedge sys_clk)
    begin
        if (!rstn)
            phy_reset <= 1'b1;
        else if (clk_en)
            phy_reset <= hw_rst_reg;
    end

    // ----------------------------------------
    // Strap capture
    // ----------------------------------------
    // Pins are released during reset so the straps can be read
    reg [5:0] pol_reg;
    reg mode1_strap_reg;

    always @(posedge sys_clk)
    begin
        if (clk_en && any_rst)
        begin
            pol_reg <= sync2_reg[7:2];
            mode1_strap_reg <= sync2_reg[1];
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [2:0] ctrl_a_reg;
    reg [2:0] ctrl_b_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [1:0] irq_stat_next;
    reg [1:0] irq_prev_reg;
    wire [1:0] irq_rise;

    assign irq_rise = port_irq & ~irq_prev_reg;

    // Set wins over write-one-to-clear in the same cycle
    always @*
    begin
        irq_stat_next = irq_stat_reg;
        if (reg_wr && reg_addr == {1'b0, `PLC_OFS_IRQ_STAT})
            irq_stat_next = irq_stat_next & ~reg_wdata[1:0];
        irq_stat_next = irq_stat_next | irq_rise;
    end

    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            ctrl_a_reg <= `PLC_CTRL_RST;
            ctrl_b_reg <= `PLC_CTRL_RST;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            irq_prev_reg <= 2'h0;
            reg_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            irq_prev_reg <= port_irq;
            irq_stat_reg <= irq_stat_next;
            if (reg_wr)
            begin
                case (reg_addr)
                    {1'b0, `PLC_OFS_CTRL_A}: ctrl_a_reg <= reg_wdata[2:0];
                    {1'b0, `PLC_OFS_CTRL_B}: ctrl_b_reg <= reg_wdata[2:0];
                    `PLC_OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[1:0];
                    default: ;
                endcase
            end
            // Read data valid in the next cycle only
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    {1'b0, `PLC_OFS_CTRL_A}: reg_rdata <= {5'h00, ctrl_a_reg};
                    {1'b0, `PLC_OFS_CTRL_B}: reg_rdata <= {5'h00, ctrl_b_reg};
                    {1'b0, `PLC_OFS_STAT}: reg_rdata <= {power_down, mode1_strap_reg, 1'b0, link_good, speed_100};
                    {1'b0, `PLC_OFS_IRQ_STAT}: reg_rdata <= {6'h00, irq_stat_reg};
                    `PLC_OFS_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_reg};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ----------------------------------------
    // Blink timer
    // ----------------------------------------
    reg [26:0] blink_cnt_reg;
    reg blink_reg;

    // Fixed slow toggle so the eye can see activity
    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            blink_cnt_reg <= 27'h0000000;
            blink_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (blink_cnt_reg >= BLINK_CYC[26:0] - 27'h0000001)
            begin
                blink_cnt_reg <= 27'h0000000;
                blink_reg <= ~blink_reg;
            end
            else
                blink_cnt_reg <= blink_cnt_reg + 27'h0000001;
        end
    end

    // ----------------------------------------
    // Indicator decode
    // ----------------------------------------
    // Returns {link, speed, third} logical on-states for one port
    function [2:0] led_on;
        input [1:0] mode;
        input dup_sel;
        input lnk;
        input spd;
        input act;
        input col;
        input dup;
        input blk;
        reg l;
        reg t;
        begin
            l = 1'b0;
            t = 1'b0;
            case (mode)
                `PLC_MODE1:
                begin
                    l = lnk;
                    t = act;
                end
                `PLC_MODE2:
                begin
                    l = lnk && !(act && blk);
                    t = col;
                end
                `PLC_MODE3:
                begin
                    l = lnk && !(act && blk);
                    t = dup_sel ? dup : col;
                end
                default:
                begin
                    l = lnk;
                    t = act;
                end
            endcase
            led_on = {l, spd, t};
        end
    endfunction

    // Register mode 3 overrides the strap choice
    wire [1:0] mode_a;
    wire [1:0] mode_b;
    wire [2:0] on_a;
    wire [2:0] on_b;

    assign mode_a = ctrl_a_reg[`PLC_CTRL_MODE3] ? `PLC_MODE3 : (mode1_strap_reg ? `PLC_MODE1 : `PLC_MODE2);
    assign mode_b = ctrl_b_reg[`PLC_CTRL_MODE3] ? `PLC_MODE3 : (mode1_strap_reg ? `PLC_MODE1 : `PLC_MODE2);
    // Each port decodes from its own status bits only
    assign on_a = led_on(mode_a, ctrl_a_reg[`PLC_CTRL_DUPLEX], link_good[0], speed_100[0],
                         activity[0], collision[0], full_duplex[0], blink_reg);
    assign on_b = led_on(mode_b, ctrl_b_reg[`PLC_CTRL_DUPLEX], link_good[1], speed_100[1],
                         activity[1], collision[1], full_duplex[1], blink_reg);

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Strapped low (pulled down) means active high LED; pulled up means active low
    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            // Release pins so the straps can be sensed
            link_indicator_port_a_oe <= 1'b0;
            link_indicator_port_b_oe <= 1'b0;
            speed_indicator_port_a_oe <= 1'b0;
            speed_indicator_port_b_oe <= 1'b0;
            activity_collision_indicator_port_a_oe <= 1'b0;
            activity_collision_indicator_port_b_oe <= 1'b0;
            link_indicator_port_a_out <= 1'b0;
            link_indicator_port_b_out <= 1'b0;
            speed_indicator_port_a_out <= 1'b0;
            speed_indicator_port_b_out <= 1'b0;
            activity_collision_indicator_port_a_out <= 1'b0;
            activity_collision_indicator_port_b_out <= 1'b0;
        end
        else if (clk_en)
        begin
            link_indicator_port_a_oe <= 1'b1;
            link_indicator_port_b_oe <= 1'b1;
            speed_indicator_port_a_oe <= 1'b1;
            speed_indicator_port_b_oe <= 1'b1;
            activity_collision_indicator_port_a_oe <= 1'b1;
            activity_collision_indicator_port_b_oe <= 1'b1;
            link_indicator_port_a_out <= on_a[2] ^ pol_reg[0];
            link_indicator_port_b_out <= on_b[2] ^ pol_reg[1];
            speed_indicator_port_a_out <= on_a[1] ^ pol_reg[2];
            speed_indicator_port_b_out <= on_b[1] ^ pol_reg[3];
            activity_collision_indicator_port_a_out <= on_a[0] ^ pol_reg[4];
            activity_collision_indicator_port_b_out <= on_b[0] ^ pol_reg[5];
        end
    end

    // Open-drain: output level is always low, only the enable moves
    assign powerdown_or_irq_port_a_out = 1'b0;
    assign powerdown_or_irq_port_b_out = 1'b0;

    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            powerdown_or_irq_port_a_oe <= 1'b0;
            powerdown_or_irq_port_b_oe <= 1'b0;
            power_down <= 2'h0;
        end
        else if (clk_en)
        begin
            // Pin becomes interrupt output only once software asks
            powerdown_or_irq_port_a_oe <= ctrl_a_reg[`PLC_CTRL_IRQ_EN] && port_irq[0];
            powerdown_or_irq_port_b_oe <= ctrl_b_reg[`PLC_CTRL_IRQ_EN] && port_irq[1];
            power_down[0] <= !ctrl_a_reg[`PLC_CTRL_IRQ_EN] && !sync2_reg[8];
            power_down[1] <= !ctrl_b_reg[`PLC_CTRL_IRQ_EN] && !sync2_reg[9];
        end
    end

endmodule // plc_top

// ### sim/plc_checker.sv
// Checker for plc_top: register port, interrupt, reset and pin timing.
// Assumes it is bound to plc_top and that clk_en stays high while it watches.
`timescale 1ns/1ns
module plc_checker (
    input wire sys_clk,
    input wire rstn,
    input wire hw_reset_n_pin,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire irq,
    input wire [1:0] speed_100,
    input wire [1:0] port_irq,
    input wire speed_indicator_port_a_out,
    input wire speed_indicator_port_a_oe,
    input wire link_indicator_port_a_oe,
    input wire powerdown_or_irq_port_a_in,
    input wire powerdown_or_irq_port_a_out,
    input wire powerdown_or_irq_port_a_oe,
    input wire powerdown_or_irq_port_b_out,
    input wire [1:0] power_down,
    input wire phy_reset
);
    // ----------------------------------------
    // Common clock and reset
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Reset pin released long enough to pass the synchroniser
    sequence s_pin_up;
        hw_reset_n_pin [*5];
    endsequence
    // Speed input moves while the pin is already driven
    sequence s_spd_move;
        speed_indicator_port_a_oe && $past(speed_indicator_port_a_oe) && !phy_reset && $changed(speed_100[0]);
    endsequence

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");

    // Sticky status only clears by software or by a hardware reset
    property p_irq_fall;
        $fell(irq) |-> ($past(reg_wr) || phy_reset) or (##1 phy_reset);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");

    property p_speed;
        s_spd_move |=> phy_reset || $changed(speed_indicator_port_a_out);
    endproperty
    a_speed: assert property (p_speed) else $error("speed indicator did not follow speed");

    property p_phy_rel;
        s_pin_up |=> !phy_reset;
    endproperty
    a_phy_rel: assert property (p_phy_rel) else $error("internal reset stuck after pin release");

    // Pins must be released in reset so the straps can be sensed
    property p_quiet;
        $rose(phy_reset) |=> !link_indicator_port_a_oe && !speed_indicator_port_a_oe && !powerdown_or_irq_port_a_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pin driven during reset");

    property p_pd_rise;
        $rose(power_down[0]) |-> !$past(powerdown_or_irq_port_a_in, 3);
    endproperty
    a_pd_rise: assert property (p_pd_rise) else $error("power down without low pin");

    property p_od_out;
        powerdown_or_irq_port_a_out == 1'b0 && powerdown_or_irq_port_b_out == 1'b0;
    endproperty
    a_od_out: assert property (p_od_out) else $error("open drain pin drives high");

    property p_oe_irq;
        powerdown_or_irq_port_a_oe |-> $past(port_irq[0]);
    endproperty
    a_oe_irq: assert property (p_oe_irq) else $error("pin pulled low without own interrupt");
endmodule // plc_checker

bind plc_top plc_checker u_plc_checker (
    .sys_clk(sys_clk), .rstn(rstn), .hw_reset_n_pin(hw_reset_n_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .speed_100(speed_100), .port_irq(port_irq),
    .speed_indicator_port_a_out(speed_indicator_port_a_out), .speed_indicator_port_a_oe(speed_indicator_port_a_oe),
    .link_indicator_port_a_oe(link_indicator_port_a_oe), .powerdown_or_irq_port_a_in(powerdown_or_irq_port_a_in),
    .powerdown_or_irq_port_a_out(powerdown_or_irq_port_a_out),
    .powerdown_or_irq_port_a_oe(powerdown_or_irq_port_a_oe),
    .powerdown_or_irq_port_b_out(powerdown_or_irq_port_b_out), .power_down(power_down), .phy_reset(phy_reset));

// ### sim/plc_board.sv
// Board model: strap resistors on the indicator pins, power-management driver.
// Assumes the out/oe/in split of the design's two-way pins.
`timescale 1ns/1ns
module plc_board (
    input wire [5:0] led_out,
    input wire [5:0] led_oe,
    input wire [5:0] pull,
    input wire [1:0] pd_oe,
    input wire [1:0] pd_req_n,
    output wire [5:0] led_in,
    output wire [1:0] pd_in
);
    // Undriven pins rest at the strap resistor level, never at the last value
    assign led_in = (led_oe & led_out) | (~led_oe & pull);
    // Wired-AND: open drain against the system driver, pull-up when released
    assign pd_in = ~pd_oe & pd_req_n;
endmodule // plc_board

// ### sim/testbench.sv
// Self-checking bench for plc_top with the board model.
// Assumes short blink and reset counts; vectors bit0 port A, bit1 port B.
`timescale 1ns/1ns
module testbench;
    localparam BL = 8;
    localparam RC = 4;
    reg sys_clk = 1'b0;
    reg rstn = 1'b0;
    reg clk_en = 1'b1;
    reg pin_n = 1'b1;
    reg [4:0] ra = 5'h00;
    reg [7:0] wd = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [1:0] lg = 2'h0, sp = 2'h0, ac = 2'h0, co = 2'h0, fd = 2'h0, pi = 2'h0;
    // Mode strap high selects mode 1; only link A is pulled up
    reg ms = 1'b1;
    reg [5:0] pull = 6'h01;
    reg [1:0] pdr = 2'h3;
    wire [7:0] rdat;
    wire irq;
    // LED order: link a, link b, speed a, speed b, third a, third b
    wire [5:0] lo, le, li;
    wire [1:0] po, pe, pn, pwd;
    wire phy_rst;
    integer error_cnt = 0;
    integer checks_done = 0;
    integer cyc = 0;

    always #5 sys_clk = ~sys_clk;

    plc_top #(.BLINK_CYC(BL), .RST_CYC(RC)) u_plc_top (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .hw_reset_n_pin(pin_n),
        .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .irq(irq),
        .link_good(lg), .speed_100(sp), .activity(ac), .collision(co), .full_duplex(fd),
        .port_irq(pi), .mode_strap_pin(ms),
        .link_indicator_port_a_in(li[0]), .link_indicator_port_a_out(lo[0]), .link_indicator_port_a_oe(le[0]),
        .link_indicator_port_b_in(li[1]), .link_indicator_port_b_out(lo[1]), .link_indicator_port_b_oe(le[1]),
        .speed_indicator_port_a_in(li[2]), .speed_indicator_port_a_out(lo[2]), .speed_indicator_port_a_oe(le[2]),
        .speed_indicator_port_b_in(li[3]), .speed_indicator_port_b_out(lo[3]), .speed_indicator_port_b_oe(le[3]),
        .activity_collision_indicator_port_a_in(li[4]), .activity_collision_indicator_port_a_out(lo[4]),
        .activity_collision_indicator_port_a_oe(le[4]), .activity_collision_indicator_port_b_in(li[5]),
        .activity_collision_indicator_port_b_out(lo[5]), .activity_collision_indicator_port_b_oe(le[5]),
        .powerdown_or_irq_port_a_in(pn[0]), .powerdown_or_irq_port_a_out(po[0]), .powerdown_or_irq_port_a_oe(pe[0]),
        .powerdown_or_irq_port_b_in(pn[1]), .powerdown_or_irq_port_b_out(po[1]), .powerdown_or_irq_port_b_oe(pe[1]),
        .power_down(pwd), .phy_reset(phy_rst));

    plc_board u_plc_board (.led_out(lo), .led_oe(le), .pull(pull), .pd_oe(pe), .pd_req_n(pdr), .led_in(li), .pd_in(pn));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task tally_and_finish;
        $display("checks=%0d errors=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Wait n edges, then step past them so outputs are settled
    task wt(input integer n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(rdat, e);
    endtask

    // Low pulse on the reset pin, then time for the synchroniser
    task pulse(input integer n);
        @(posedge sys_clk);
        pin_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        pin_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        rd_reg(5'h00, 8'h00);
        rd_reg(5'h10, 8'h00);
        wr_reg(5'h14, 8'hFF);
        rd_reg(5'h14, 8'h00);
        wr_reg(5'h04, 8'h07);
        rd_reg(5'h04, 8'h07);
        wr_reg(5'h04, 8'h00);
    endtask

    task t_mode1;
        @(posedge sys_clk);
        lg <= 2'b01;
        sp <= 2'b10;
        ac <= 2'b01;
        wt(3);
        chk(le, 8'h3F);
        chk(lo, 8'h18);
        rd_reg(5'h08, 8'h26);
        @(posedge sys_clk);
        lg <= 2'b00;
        wt(3);
        chk(lo, 8'h19);
    endtask

    task t_mode3;
        @(posedge sys_clk);
        sp <= 2'b01;
        co <= 2'b10;
        fd <= 2'b01;
        wr_reg(5'h00, 8'h03);
        wt(3);
        chk(lo, 8'h15);
        wr_reg(5'h00, 8'h01);
        wt(3);
        chk(lo, 8'h05);
    endtask

    task t_hwreset;
        reg [1:0] s;
        pulse(2);
        rd_reg(5'h00, 8'h01);
        ms <= 1'b0;
        pulse(RC + 6);
        rd_reg(5'h00, 8'h00);
        rd_reg(5'h08, 8'h01);
        @(posedge sys_clk);
        lg <= 2'b01;
        ac <= 2'b00;
        co <= 2'b01;
        wt(3);
        chk(lo & 6'h11, 8'h10);
        @(posedge sys_clk);
        ac <= 2'b01;
        s = 2'b00;
        repeat (4 * BL)
        begin
            wt(1);
            s[lo[0]] = 1'b1;
        end
        chk(s, 8'h03);
    endtask

    task t_irq;
        wr_reg(5'h10, 8'h01);
        @(posedge sys_clk);
        pi <= 2'b11;
        wt(2);
        chk(irq, 8'h01);
        rd_reg(5'h0C, 8'h03);
        @(posedge sys_clk);
        pi <= 2'b00;
        wr_reg(5'h0C, 8'h01);
        #1;
        chk(irq, 8'h00);
        rd_reg(5'h0C, 8'h02);
        @(posedge sys_clk);
        pi <= 2'b11;
        wt(3);
        chk({pe, pn}, 8'h03);
        wr_reg(5'h00, 8'h04);
        wt(3);
        chk({pe, pn}, 8'h06);
        chk(pwd, 8'h00);
        @(posedge sys_clk);
        pi <= 2'b00;
        wr_reg(5'h00, 8'h00);
        @(posedge sys_clk);
        pdr <= 2'b10;
        wt(4);
        chk(pwd, 8'h01);
        rd_reg(5'h08, 8'h45);
        @(posedge sys_clk);
        pdr <= 2'b11;
        wt(4);
        chk(pwd, 8'h00);
    endtask

    // ----------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs;
        t_mode1;
        t_mode3;
        t_hwreset;
        t_irq;
        tally_and_finish;
    end

    // About 150 cycles are expected; 3000 means a hang
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            tally_and_finish;
        end
    end
endmodule // testbench
